// file: verilog/rmii_rx_phy.sv
// RMII receive path, crossover selection, power modes and management registers.
//
// What this block does
// R1: Deliver two fresh bits per reference clock with carrier.
// R2: Hold receive data at 00 without carrier.
// R3: Partner ignores receive data without carrier.
// R4: Raise receive error for erroneous frame symbols.
// R5: Partner ignores receive error without carrier.
// R6: Partner derives collision from its transmit and carrier.
// R7: Automatic crossover follows the sensed partner pairs.
// R8: Automatic crossover on at reset, off by bit.
// R9: Manual bit picks straight or crossed pairs.
// R10: Power saving needs autoneg, no cable, enable bit.
// R11: Power saving keeps transmitter, energy detect, synthesiser.
// R12: Power saving stops receive clock until link.
// R13: Clearing power-saving bit disables power saving.
// R14: Power-down bit stops the whole device.
// R15: Management port keeps working during power-down.
// R16: Management address map decodes as listed.
// R17: Carrier asserted while medium busy, dropped on loss.
// R18: Reference clock times every receive output; power-down clears them on the next system clock instead.
// R19: Reserved addresses read zero, ignore writes.
// R20: Clearing power-down bit resumes normal operation.

`include "rmii_rx_phy_map.svh"

// Synchronous FIFO with valid/ready on both sides and a flush.
module rx_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (s_q.count != DEPTH[AW:0]);
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;

  // Pointer and occupancy update; a flush empties the buffer at once.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.count = '0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rx_fifo

// Receive half of the RMII port with the management register file.
module rmii_rx_phy #(
  parameter logic [4:0] PHY_ADDRESS = 5'h01,
  parameter logic [15:0] IDENT_HIGH = 16'h1234, // Arbitrary value.
  parameter logic [15:0] IDENT_LOW = 16'h5670 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // RMII receive toward the MAC.
  input wire logic ref_clk,
  output logic crs_dv,
  output logic [1:0] rxd,
  output logic rx_er,
  // Management port.
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Recovered stream and line status from the decoder.
  input wire rmii_rx_phy_pkg::rx_word_t line_word,
  input wire logic line_valid,
  output logic line_ready,
  input wire logic line_carrier,
  input wire logic line_cable,
  input wire logic line_link_up,
  // Crossover.
  input wire logic pairs_sensed_crossed,
  output logic mdix_crossed,
  // Power control.
  output rmii_rx_phy_pkg::power_gate_t power_gate,
  output logic power_saving,
  output logic power_down,
  output logic rxc_enable
);

  typedef struct packed {
    rmii_rx_phy_pkg::sync3_t ref_s;
    rmii_rx_phy_pkg::sync3_t mdc_s;
    rmii_rx_phy_pkg::sync3_t mdio_s;
    rmii_rx_phy_pkg::mgmt_state_t mst;
    logic [4:0] cnt;
    logic [11:0] hdr;
    logic mine;
    logic [15:0] sh;
    logic mdio_o;
    logic mdio_oe;
    logic [15:0] ctrl;
    logic [`SLOT_COUNT-1:0][15:0] rw;
    logic [15:0] err_cnt;
    logic crs;
    logic [1:0] rxd;
    logic rx_er;
    logic crossed;
    logic rxc_on;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    mst: rmii_rx_phy_pkg::MGMT_IDLE,
    ctrl: `BASIC_CONTROL_RESET,
    rw: {`VENDOR_B_RESET, 80'h0},
    rxc_on: 1'b1,
    default: '0
  };

  core_state_t s_q;
  core_state_t s_d;
  rmii_rx_phy_pkg::rx_word_t fifo_word;
  logic fifo_valid;
  logic fifo_in_ready;
  logic fifo_out_ready;
  logic ref_rise;
  logic mdc_rise;
  logic mdio_bit;
  logic pd;
  logic psave;
  logic pop;
  logic is_read;
  logic [15:0] rdata;
  logic [15:0] wdata;
  logic [3:0] wslot;

  // Slot of a plain read/write register; the top bit marks a hit.
  function automatic logic [3:0] slot_of(input logic [4:0] addr);
    logic [3:0] r;
    r = 4'h0;
    case (addr)
      `REG_AUTONEG_ADVERTISE: r = {1'b1, `SLOT_ADVERTISE};
      `REG_AUTONEG_NEXT_PAGE: r = {1'b1, `SLOT_NEXT_PAGE};
      `REG_INTERFACE_CONTROL: r = {1'b1, `SLOT_INTERFACE};
      `REG_IRQ_CONTROL_STATUS: r = {1'b1, `SLOT_IRQ};
      `REG_VENDOR_CONTROL_A: r = {1'b1, `SLOT_VENDOR_A};
      `REG_VENDOR_CONTROL_B: r = {1'b1, `SLOT_VENDOR_B};
      default: r = 4'h0;
    endcase
    return r;
  endfunction : slot_of

  // A filtered edge counts once the second and third stages agree.
  function automatic logic rose(input rmii_rx_phy_pkg::sync3_t v);
    return (v.stage[1] == v.stage[2]) & v.stage[2] & ~v.level;
  endfunction : rose

  // Received buffer between the decoder and the reference clock timing.
  rx_fifo #(
    .WIDTH($bits(rmii_rx_phy_pkg::rx_word_t)),
    .DEPTH(`RX_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(pd),
    .in_data(line_word),
    .in_valid(line_valid & ~pd & ~psave),
    .in_ready(fifo_in_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_out_ready)
  );

  // Edge detection on the synchronised reference clock and management clock.
  assign ref_rise = rose(s_q.ref_s); // see R18
  assign mdc_rise = rose(s_q.mdc_s);
  assign mdio_bit = s_q.mdio_s.stage[2];

  // Mode decode from the control registers.
  assign pd = s_q.ctrl[`CTRL_POWER_DOWN_BIT]; // see R14, R20
  assign psave = s_q.ctrl[`CTRL_AUTONEG_BIT] & ~line_cable & ~pd
    & s_q.rw[`SLOT_VENDOR_B][`VCB_POWER_SAVE_BIT]; // see R10, R13

  // The buffer drains one word per reference edge; halted in power-down.
  assign fifo_out_ready = ref_rise & ~pd; // see R1, R14
  assign pop = fifo_out_ready & fifo_valid;
  assign line_ready = fifo_in_ready & ~pd & ~psave;

  // Frame fields of the management header and the current data word.
  assign is_read = (s_q.hdr[11:10] == `MGMT_OP_READ);
  assign wdata = {s_q.sh[14:0], mdio_bit};
  assign wslot = slot_of(s_q.hdr[4:0]);

  // Read decode of the management address space.
  always_comb begin
    rdata = 16'h0000; // see R19
    case (s_q.hdr[4:0]) // see R16
      `REG_BASIC_CONTROL: rdata = s_q.ctrl;
      `REG_BASIC_STATUS: rdata = `BASIC_STATUS_CAPS
        | ({15'h0000, line_link_up} << `STATUS_LINK_BIT);
      `REG_IDENTIFIER_HIGH: rdata = IDENT_HIGH;
      `REG_IDENTIFIER_LOW: rdata = IDENT_LOW;
      `REG_RX_ERROR_COUNTER: rdata = s_q.err_cnt;
      default: begin
        if (wslot[3]) begin
          rdata = s_q.rw[wslot[2:0]];
        end
      end
    endcase
  end

  // Next-state logic of synchronisers, management frames, registers and receive path.
  always_comb begin
    s_d = s_q;
    // Each input passes three stages; the level follows once the last two agree.
    s_d.ref_s.stage = {s_q.ref_s.stage[1:0], ref_clk};
    s_d.mdc_s.stage = {s_q.mdc_s.stage[1:0], mdc};
    s_d.mdio_s.stage = {s_q.mdio_s.stage[1:0], mdio_i};
    if (s_q.ref_s.stage[1] == s_q.ref_s.stage[2]) begin
      s_d.ref_s.level = s_q.ref_s.stage[2];
    end
    if (s_q.mdc_s.stage[1] == s_q.mdc_s.stage[2]) begin
      s_d.mdc_s.level = s_q.mdc_s.stage[2];
    end
    if (s_q.mdio_s.stage[1] == s_q.mdio_s.stage[2]) begin
      s_d.mdio_s.level = s_q.mdio_s.stage[2];
    end

    // Error counter counts delivered errored di-bits and saturates.
    if (pop && fifo_word.err && s_q.err_cnt != 16'hffff) begin
      s_d.err_cnt = s_q.err_cnt + 16'h0001;
    end

    // Management frames run in every mode, power-down included.
    if (mdc_rise) begin // see R15
      case (s_q.mst)
        rmii_rx_phy_pkg::MGMT_IDLE: begin
          if (!mdio_bit) begin
            s_d.mst = rmii_rx_phy_pkg::MGMT_START;
          end
        end
        rmii_rx_phy_pkg::MGMT_START: begin
          s_d.cnt = 5'h00;
          s_d.mst = mdio_bit ? rmii_rx_phy_pkg::MGMT_HEADER : rmii_rx_phy_pkg::MGMT_IDLE;
        end
        rmii_rx_phy_pkg::MGMT_HEADER: begin
          s_d.hdr = {s_q.hdr[10:0], mdio_bit};
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `MGMT_HEADER_LAST) begin
            // Frames for another address or with a bad opcode are walked but not acted on.
            s_d.mine = (s_d.hdr[9:5] == PHY_ADDRESS)
              && (s_d.hdr[11:10] == `MGMT_OP_READ || s_d.hdr[11:10] == `MGMT_OP_WRITE);
            s_d.cnt = 5'h00;
            s_d.mst = rmii_rx_phy_pkg::MGMT_TURN;
          end
        end
        rmii_rx_phy_pkg::MGMT_TURN: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00) begin
            // Second turnaround bit is driven low on a read.
            s_d.mdio_oe = s_q.mine & is_read;
            s_d.mdio_o = 1'b0;
          end else begin
            s_d.cnt = 5'h00;
            s_d.mst = rmii_rx_phy_pkg::MGMT_DATA;
            if (is_read) begin
              s_d.mdio_o = s_q.mine & rdata[15];
              s_d.sh = {rdata[14:0], 1'b0};
              // Reading the error counter clears it; a same-cycle error still counts.
              if (s_q.mine && s_q.hdr[4:0] == `REG_RX_ERROR_COUNTER) begin
                s_d.err_cnt = {15'h0000, pop & fifo_word.err};
              end
            end
          end
        end
        rmii_rx_phy_pkg::MGMT_DATA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (is_read) begin
            s_d.mdio_o = s_q.mine & s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
          end else begin
            s_d.sh = wdata;
          end
          if (s_q.cnt == `MGMT_DATA_LAST) begin
            s_d.mst = rmii_rx_phy_pkg::MGMT_IDLE;
            s_d.mdio_oe = 1'b0;
            s_d.mdio_o = 1'b0;
            if (s_q.mine && !is_read) begin
              if (s_q.hdr[4:0] == `REG_BASIC_CONTROL) begin
                if (wdata[`CTRL_SOFT_RESET_BIT]) begin
                  // Software reset restores every register default.
                  s_d.ctrl = STATE_RESET.ctrl;
                  s_d.rw = STATE_RESET.rw;
                  s_d.err_cnt = {15'h0000, pop & fifo_word.err}; // A same-cycle error still counts.
                end else begin
                  s_d.ctrl = wdata & `BASIC_CONTROL_WMASK; // see R14, R20
                end
              end else if (wslot[3]) begin
                s_d.rw[wslot[2:0]] = wdata; // see R8, R9, R13, R16
              end
            end
          end
        end
        default: begin
          s_d.mst = rmii_rx_phy_pkg::MGMT_IDLE;
          s_d.mdio_oe = 1'b0;
        end
      endcase
    end

    // Receive outputs change only on reference edges outside power-down; carrier tracks the medium.
    if (ref_rise) begin // see R18
      s_d.crs = ~pd & (line_carrier | fifo_valid); // see R17
      if (s_d.crs && fifo_valid) begin
        s_d.rxd = fifo_word.dibit; // see R1
        s_d.rx_er = fifo_word.err; // see R4
      end else begin
        s_d.rxd = 2'h0; // see R2
        s_d.rx_er = 1'b0;
      end
    end
    if (pd) begin
      // Power-down silences the receive outputs at once.
      s_d.crs = 1'b0; // see R14
      s_d.rxd = 2'h0; // see R2
      s_d.rx_er = 1'b0;
    end

    // Pair assignment follows the sensed pairs until link, or the manual choice.
    if (!s_q.rw[`SLOT_VENDOR_B][`VCB_MDIX_DISABLE_BIT]) begin
      if (!line_link_up) begin
        s_d.crossed = pairs_sensed_crossed; // see R7, R8
      end
    end else begin
      s_d.crossed = s_q.rw[`SLOT_VENDOR_B][`VCB_MDIX_MANUAL_BIT]; // see R9
    end

    // Receive clock stops in power saving and returns with cable and link.
    if (psave || pd) begin
      s_d.rxc_on = 1'b0; // see R12
    end else if (line_cable && line_link_up) begin
      s_d.rxc_on = 1'b1; // see R12
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Block enables: power saving keeps transmit, energy detect and synthesiser.
  assign power_gate.transmitter = ~pd; // see R11, R14
  assign power_gate.energy_detect = ~pd; // see R11
  assign power_gate.synthesiser = ~pd; // see R11
  assign power_gate.receiver = ~pd & ~psave; // see R11

  // Registered outputs, except power_saving, which also decodes line_cable directly.
  assign crs_dv = s_q.crs;
  assign rxd = s_q.rxd;
  assign rx_er = s_q.rx_er;
  assign mdio_o = s_q.mdio_o;
  assign mdio_oe = s_q.mdio_oe;
  assign mdix_crossed = s_q.crossed;
  assign rxc_enable = s_q.rxc_on;
  assign power_saving = psave;
  assign power_down = pd;

endmodule : rmii_rx_phy

// file: pkg/rmii_rx_phy_map.svh
// Register offsets, field positions, reset values and sizes of the receive PHY block.
`ifndef RMII_RX_PHY_MAP_SVH
`define RMII_RX_PHY_MAP_SVH

// Management register offsets.
`define REG_BASIC_CONTROL 5'h00
`define REG_BASIC_STATUS 5'h01
`define REG_IDENTIFIER_HIGH 5'h02
`define REG_IDENTIFIER_LOW 5'h03
`define REG_AUTONEG_ADVERTISE 5'h04
`define REG_PARTNER_ABILITY 5'h05
`define REG_AUTONEG_EXPANSION 5'h06
`define REG_AUTONEG_NEXT_PAGE 5'h07
`define REG_PARTNER_NEXT_PAGE 5'h08
`define REG_INTERFACE_CONTROL 5'h14
`define REG_RX_ERROR_COUNTER 5'h15
`define REG_IRQ_CONTROL_STATUS 5'h1b
`define REG_VENDOR_CONTROL_A 5'h1e
`define REG_VENDOR_CONTROL_B 5'h1f

// Storage slots of the plain read/write registers.
`define SLOT_COUNT 6
`define SLOT_ADVERTISE 3'h0
`define SLOT_NEXT_PAGE 3'h1
`define SLOT_INTERFACE 3'h2
`define SLOT_IRQ 3'h3
`define SLOT_VENDOR_A 3'h4
`define SLOT_VENDOR_B 3'h5

// Field positions.
`define CTRL_SOFT_RESET_BIT 15
`define CTRL_AUTONEG_BIT 12
`define CTRL_POWER_DOWN_BIT 11
`define STATUS_LINK_BIT 2
`define VCB_MDIX_MANUAL_BIT 14
`define VCB_MDIX_DISABLE_BIT 13
`define VCB_POWER_SAVE_BIT 10

// Reset values and write masks.
`define BASIC_CONTROL_RESET 16'h3100
`define BASIC_CONTROL_WMASK 16'h7d81
`define BASIC_STATUS_CAPS 16'h7808
`define VENDOR_B_RESET 16'h0000

// Management frame layout.
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_HEADER_LAST 5'h0b
`define MGMT_DATA_LAST 5'h0f

// Receive buffer size.
`define RX_FIFO_DEPTH 16

`endif

// file: pkg/rmii_rx_phy_pkg.sv
// Types shared by the receive PHY block.
package rmii_rx_phy_pkg;

  // One recovered di-bit with its symbol error flag.
  typedef struct packed {
    logic err;
    logic [1:0] dibit;
  } rx_word_t;

  // Management frame states, Gray coded along the frame.
  typedef enum logic [2:0] {
    MGMT_IDLE = 3'h0,
    MGMT_START = 3'h1,
    MGMT_HEADER = 3'h3,
    MGMT_TURN = 3'h2,
    MGMT_DATA = 3'h6
  } mgmt_state_t;

  // Enables of the transceiver's functional blocks.
  typedef struct packed {
    logic transmitter;
    logic energy_detect;
    logic synthesiser;
    logic receiver;
  } power_gate_t;

  // Three-stage input synchroniser with its filtered level.
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync3_t;

endpackage : rmii_rx_phy_pkg

// file: testbench/rmii_rx_phy_checker.sv
// Concurrent checks on the ports of the receive PHY block.
module rmii_rx_phy_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Watched ports.
  input wire logic ref_clk,
  input wire logic crs_dv,
  input wire logic [1:0] rxd,
  input wire logic rx_er,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic line_cable,
  input wire logic line_ready,
  input wire rmii_rx_phy_pkg::power_gate_t power_gate,
  input wire logic power_saving,
  input wire logic power_down,
  input wire logic rxc_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_q;
  logic [3:0] since_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Counts cycles since the last reference clock rise, so output moves can be timed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= 1'b0;
      since_q <= 4'hf;
    end else begin
      ref_q <= ref_clk;
      since_q <= (ref_clk && !ref_q) ? 4'h0 : ((since_q == 4'hf) ? since_q : since_q + 4'h1);
    end
  end

  // A power-saving spell of two cycles.
  sequence s_saving_held;
    power_saving [*2];
  endsequence

  property p_idle_zero; !crs_dv |-> rxd == 2'h0; endproperty
  property p_err_gated; rx_er |-> crs_dv; endproperty
  property p_pd_quiet; power_down |-> !line_ready ##1 (!crs_dv && !rx_er); endproperty
  property p_saving_gate; power_saving |-> power_gate == 4'he && !line_ready; endproperty
  property p_saving_cause; power_saving |-> !line_cable; endproperty
  property p_rxc_off; s_saving_held |-> !rxc_enable; endproperty
  property p_dibit_timing; $changed(rxd) && !power_down |-> since_q inside {[2:6]}; endproperty
  property p_carrier_timing; $changed(crs_dv) && !power_down |-> since_q inside {[2:6]};
  endproperty
  property p_turn_zero; $rose(mdio_oe) |-> !mdio_o; endproperty

  a_idle_zero: assert property (p_idle_zero)
    else $error("receive data not idle without carrier");
  a_err_gated: assert property (p_err_gated)
    else $error("receive error without carrier");
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("receive side active in power-down");
  a_saving_gate: assert property (p_saving_gate)
    else $error("wrong blocks kept alive in power saving");
  a_saving_cause: assert property (p_saving_cause)
    else $error("power saving with cable present");
  a_rxc_off: assert property (p_rxc_off)
    else $error("receive clock runs in power saving");
  a_dibit_timing: assert property (p_dibit_timing)
    else $error("receive data moved off the reference clock");
  a_carrier_timing: assert property (p_carrier_timing)
    else $error("carrier moved off the reference clock");
  a_turn_zero: assert property (p_turn_zero)
    else $error("turnaround bit not driven low");
endmodule : rmii_rx_phy_checker

bind rmii_rx_phy rmii_rx_phy_checker rmii_rx_phy_checker_i (
  .clk(clk), .rstn(rstn), .ref_clk(ref_clk), .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er),
  .mdio_o(mdio_o), .mdio_oe(mdio_oe), .line_cable(line_cable), .line_ready(line_ready),
  .power_gate(power_gate), .power_saving(power_saving), .power_down(power_down),
  .rxc_enable(rxc_enable)
);

// file: testbench/rmii_mac_model.sv
// Behavioural MAC on the receive side of the reduced media interface.
module rmii_mac_model (
  // Reference clock for both sides.
  output logic ref_clk,
  // Receive signals from the transceiver.
  input wire logic crs_dv,
  input wire logic [1:0] rxd,
  input wire logic rx_er,
  // Own transmit enable and the collision it implies.
  input wire logic tx_en,
  output logic col
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] got[$];

  // Runs the reference clock without pause at a 64 ns period.
  initial begin
    ref_clk = 1'b0;
    #3;
    forever #32 ref_clk = ~ref_clk;
  end

  // Collision is carrier seen while transmitting.
  assign col = tx_en & crs_dv;

  // Keeps a di-bit and its error flag only while carrier is present.
  always @(posedge ref_clk) begin
    if (crs_dv === 1'b1) begin
      got.push_back({rx_er, rxd});
    end
  end
endmodule : rmii_mac_model

// file: testbench/rmii_rx_phy_tb.sv
// Self-checking testbench of the receive PHY block.
module rmii_rx_phy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID_HI = 16'h0a5c; // Arbitrary value.
  localparam logic [15:0] ID_LO = 16'h3c71; // Arbitrary value.
  logic clk, rstn, mdc, mdio_drv, mdio_o, mdio_oe, ref_clk, crs_dv, rx_er, tx_en, col;
  logic line_valid, line_ready, line_carrier, line_cable, line_link_up, saw_full;
  logic pairs_sensed_crossed, mdix_crossed, power_saving, power_down, rxc_enable;
  logic [1:0] rxd;
  wire logic mdio_i;
  rmii_rx_phy_pkg::rx_word_t line_word;
  rmii_rx_phy_pkg::power_gate_t power_gate;
  logic [4:0] resv[6] = '{5'h09, 5'h13, 5'h16, 5'h1a, 5'h1c, 5'h1d};
  logic [4:0] plain[5] = '{5'h04, 5'h07, 5'h14, 5'h1b, 5'h1e};
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  // The management line idles high when nobody drives it.
  assign mdio_i = mdio_oe ? mdio_o : mdio_drv;

  rmii_rx_phy #(.IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) rmii_rx_phy_i (
    .clk(clk), .rstn(rstn), .ref_clk(ref_clk), .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er),
    .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .line_word(line_word),
    .line_valid(line_valid), .line_ready(line_ready), .line_carrier(line_carrier),
    .line_cable(line_cable), .line_link_up(line_link_up),
    .pairs_sensed_crossed(pairs_sensed_crossed), .mdix_crossed(mdix_crossed),
    .power_gate(power_gate), .power_saving(power_saving), .power_down(power_down),
    .rxc_enable(rxc_enable)
  );
  rmii_mac_model rmii_mac_model_i (
    .ref_clk(ref_clk), .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er), .tx_en(tx_en), .col(col)
  );

  // Makes the 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short.
  always @(negedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // Compares one value and reports a mismatch.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One management bit: sets the line with clock low, samples it just before the rise.
  task automatic mbit(input logic b, output logic s);
    mdio_drv = b;
    repeat (5) @(negedge clk);
    s = mdio_i;
    mdc = 1'b1;
    repeat (5) @(negedge clk);
    mdc = 1'b0;
  endtask : mbit

  // One whole management frame; reads release the line from the turnaround on.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rv);
    logic [19:0] hdr;
    logic s;
    hdr = {4'hf, 2'b01, op, 5'h01, ra, (op == 2'h2) ? 2'b11 : 2'b10};
    for (int i = 19; i >= 0; i--) mbit(hdr[i], s);
    for (int i = 15; i >= 0; i--) begin
      mbit((op == 2'h2) ? 1'b1 : wd[i], s);
      rv[i] = s;
    end
    mdio_drv = 1'b1;
  endtask : frame

  // Register write and checked register read.
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] v;
    frame(2'h1, ra, wd, v);
  endtask : wr

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    frame(2'h2, ra, 16'h0000, v);
    check(v, exp);
  endtask : rd_chk

  // Offers one word until the block takes it; notes any refusal.
  task automatic push(input logic [2:0] w);
    int n;
    line_word = w;
    line_valid = 1'b1;
    n = 0;
    while (line_ready !== 1'b1 && n < 500) begin
      saw_full = 1'b1;
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask : push

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle

  // Main sequence.
  initial begin
    int n;
    rstn = 1'b0;
    mdc = 1'b0;
    mdio_drv = 1'b1;
    line_word = 3'h0;
    line_valid = 1'b0;
    line_carrier = 1'b0;
    line_cable = 1'b1;
    line_link_up = 1'b0;
    pairs_sensed_crossed = 1'b0;
    tx_en = 1'b0;
    saw_full = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    // Reset values, map and reserved places.
    rd_chk(5'h00, 16'h3100);
    wr(5'h01, 16'h0000);
    rd_chk(5'h01, 16'h7808);
    rd_chk(5'h02, ID_HI);
    rd_chk(5'h03, ID_LO);
    rd_chk(5'h1f, 16'h0000);
    foreach (resv[i]) begin
      wr(resv[i], 16'hffff);
      rd_chk(resv[i], 16'h0000);
    end
    // A burst of twenty words fills the buffer and is held off until it drains; one carries an error.
    // Carrier rises once the first word is buffered, so no idle di-bit is delivered with it.
    tx_en = 1'b1;
    for (int k = 0; k < 20; k++) begin
      push({k == 7, 2'(k)});
      line_carrier = 1'b1;
    end
    line_valid = 1'b0;
    line_carrier = 1'b0;
    check(saw_full, 1'b1);
    check(col, 1'b1);
    n = 0;
    while (crs_dv !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    tx_en = 1'b0;
    check(16'(rmii_mac_model_i.got.size()), 16'h0014);
    foreach (rmii_mac_model_i.got[k]) check(rmii_mac_model_i.got[k], {k == 7, 2'(k)});
    rd_chk(5'h15, 16'h0001);
    rd_chk(5'h15, 16'h0000);
    // Crossover, automatic and manual.
    pairs_sensed_crossed = 1'b1;
    settle();
    check(mdix_crossed, 1'b1);
    pairs_sensed_crossed = 1'b0;
    settle();
    check(mdix_crossed, 1'b0);
    wr(5'h1f, 16'h6000);
    settle();
    check(mdix_crossed, 1'b1);
    pairs_sensed_crossed = 1'b1;
    wr(5'h1f, 16'h2000);
    settle();
    check(mdix_crossed, 1'b0);
    wr(5'h1f, 16'h0000);
    settle();
    check(mdix_crossed, 1'b1);
    // Power saving needs all three conditions.
    wr(5'h1f, 16'h0400);
    line_cable = 1'b0;
    settle();
    check(power_saving, 1'b1);
    check(power_gate, 4'he);
    check(line_ready, 1'b0);
    check(rxc_enable, 1'b0);
    wr(5'h00, 16'h2100);
    check(power_saving, 1'b0);
    wr(5'h00, 16'h3100);
    line_cable = 1'b1;
    settle();
    check(power_saving, 1'b0);
    check(rxc_enable, 1'b0);
    line_link_up = 1'b1;
    settle();
    check(rxc_enable, 1'b1);
    rd_chk(5'h01, 16'h780c);
    line_link_up = 1'b0;
    line_cable = 1'b0;
    settle();
    check(power_saving, 1'b1);
    wr(5'h1f, 16'h0000);
    check(power_saving, 1'b0);
    line_cable = 1'b1;
    // Power-down keeps only the management port.
    wr(5'h00, 16'h3900);
    settle();
    check(power_down, 1'b1);
    check(line_ready, 1'b0);
    rd_chk(5'h00, 16'h3900);
    wr(5'h1f, 16'h0400);
    rd_chk(5'h1f, 16'h0400);
    wr(5'h00, 16'h3100);
    settle();
    check(power_down, 1'b0);
    check(line_ready, 1'b1);
    // Plain read/write registers keep what was written; the counter ignores writes.
    foreach (plain[i]) begin
      wr(plain[i], 16'ha5c3);
      rd_chk(plain[i], 16'ha5c3);
    end
    wr(5'h15, 16'hffff);
    rd_chk(5'h15, 16'h0000);
    complete_run();
  end
endmodule : rmii_rx_phy_tb
